//--- design/updown_counter_pkg.sv
// Purpose: shared constants for the 8/16-bit up/down counter/timer
// Assumes: 16-bit register port, word-indexed addresses
// Notes:   control fields are per channel; channel 1 fields idle in 16-bit mode
package updown_counter_pkg;
   // =====================================================================
   // register addresses
   localparam logic [3:0] ADDR_CTRL0  = 4'h0;
   localparam logic [3:0] ADDR_CTRL1  = 4'h1;
   localparam logic [3:0] ADDR_STAT0  = 4'h2;
   localparam logic [3:0] ADDR_STAT1  = 4'h3;
   localparam logic [3:0] ADDR_CMP    = 4'h4;
   localparam logic [3:0] ADDR_RLD    = 4'h5;
   localparam logic [3:0] ADDR_COUNT  = 4'h6;
   localparam logic [3:0] ADDR_CONFIG = 4'h7;
   // =====================================================================
   // control fields
   localparam int CTL_MODE_LSB = 0;   // 3-bit count mode
   localparam int CTL_CLKSEL   = 3;   // 0: clock/2, 1: clock/4
   localparam int CTL_RISE     = 4;   // rising edge counts (up/down mode)
   localparam int CTL_FALL     = 5;   // falling edge counts (up/down mode)
   localparam int CTL_IDX_EN   = 6;   // index input in use
   localparam int CTL_IDX_GATE = 7;   // 0: clear on edge, 1: gate
   localparam int CTL_IDX_POL  = 8;   // 1: rising edge / high level active
   localparam int CTL_ACT_LSB  = 9;   // 2-bit compare action
   localparam int CTL_IE_CMP   = 11;
   localparam int CTL_IE_WRAP  = 12;
   localparam int CTL_IE_DIR   = 13;
   localparam int CFG_WIDE     = 0;   // config: 1 = single 16-bit channel
   // =====================================================================
   // status fields
   localparam int ST_CMP  = 0;
   localparam int ST_OVF  = 1;
   localparam int ST_UNF  = 2;
   localparam int ST_DIR  = 3;
   localparam int ST_UP   = 4;        // read-only direction of last step
   // =====================================================================
   // encodings and reset values
   localparam logic [2:0] MODE_STOP  = 3'h0;
   localparam logic [2:0] MODE_TIMER = 3'h1;
   localparam logic [2:0] MODE_UPDN  = 3'h2;
   localparam logic [2:0] MODE_X2    = 3'h3;
   localparam logic [2:0] MODE_X4    = 3'h4;
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_FLAG   = 2'h1;
   localparam logic [1:0] ACT_RELOAD = 2'h2;
   localparam logic [1:0] ACT_BOTH   = 2'h3;
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] WORD_RST  = 16'h0000;
   localparam logic [1:0]  DIV4_LAST = 2'h3;  // prescaler code for clock/4 tick
endpackage

//--- design/updown_counter.sv
// Purpose: 8/16-bit up/down counter/timer with quadrature decoding
// Assumes: pins already synchronous to clk; 40 MHz clock
// Notes:   registers read back one cycle after the read strobe
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Summary of operation
// RULE_01: software picks two independent 8-bit channels or one 16-bit channel.
// RULE_02: timer mode counts on clock divided by 2 or by 4.
// RULE_03: up/down mode counts up on selected edge of phase A.
// RULE_04: up/down mode counts down on selected edge of phase B.
// RULE_05: times-two mode samples phase A on each phase B edge for direction.
// RULE_06: times-four mode also samples phase B on each phase A edge.
// RULE_07: index input clears the counter on its edge or gates counting.
// RULE_08: compare match flags, reloads, does both, or does nothing as selected.
// RULE_09: an up/down flag holds the direction of the latest step.
// RULE_10: three separately enabled interrupt conditions, one is direction change.
// RULE_11: count equal to compare value sets match flag and requests interrupt.
// RULE_12: wrap below zero or above width maximum sets a flag and requests interrupt.
module updown_counter
   import updown_counter_pkg::*;
(
   input  wire logic        clk,          // 40 MHz clock
   input  wire logic        rst_n,        // async reset, active low
   input  wire logic [3:0]  regAddr,      // register index
   input  wire logic [15:0] regWrData,    // write data
   input  wire logic        regWr,        // write strobe
   input  wire logic        regRd,        // read strobe
   output logic      [15:0] regRdData,    // read data, cycle after strobe
   input  wire logic [1:0]  phaseAInput,  // phase A pin per channel
   input  wire logic [1:0]  phaseBInput,  // phase B pin per channel
   input  wire logic [1:0]  indexInput,   // index pin per channel
   output logic      [1:0]  cmpIrq,       // compare match request per channel
   output logic      [1:0]  evtIrq        // wrap or direction request per channel
);
   // =====================================================================
   // edge helper
   function automatic logic edgeHit(input logic now, input logic prev,
                                    input logic rise, input logic fall);
      edgeHit = (rise & now & ~prev) | (fall & ~now & prev);
   endfunction

   // =====================================================================
   // storage
   // lane 1 keeps its own control and flags even while joined to lane 0
   logic [15:0] ctrlReg [0:1];
   logic [3:0]  flagReg [0:1];
   logic [1:0]  upReg;
   logic [15:0] cmpReg;
   logic [15:0] rldReg;
   logic [15:0] cntReg;
   logic        wideReg;
   logic [1:0]  prescReg;
   logic [1:0]  aPrevReg;
   logic [1:0]  bPrevReg;
   logic [1:0]  zPrevReg;

   // per-lane results
   logic [15:0] laneNext [0:1];
   logic [3:0]  laneSet  [0:1];
   logic [1:0]  laneStep;
   logic [1:0]  laneUp;

   // =====================================================================
   // divider ticks: one-cycle enables at clock/2 and clock/4
   // the prescaler runs free, so the first tick after a start may come early
   wire tick2 = prescReg[0];        // RULE_02
   wire tick4 = prescReg == DIV4_LAST;

   // =====================================================================
   // counting lanes; lane 1 is idle while the pair is joined to 16 bits
   for (genvar i = 0; i < 2; i++)
   begin : g_lane
      wire [15:0] ctl     = ctrlReg[i];
      wire [2:0]  mode    = ctl[CTL_MODE_LSB +: 3];
      wire [1:0]  act     = ctl[CTL_ACT_LSB +: 2];
      wire        wide    = (i == 0) && wideReg;
      wire        active  = (i == 0) || !wideReg;      // RULE_01
      wire        aAny    = phaseAInput[i] ^ aPrevReg[i];
      wire        bAny    = phaseBInput[i] ^ bPrevReg[i];
      wire        aSel    = edgeHit(phaseAInput[i], aPrevReg[i], ctl[CTL_RISE], ctl[CTL_FALL]);
      wire        bSel    = edgeHit(phaseBInput[i], bPrevReg[i], ctl[CTL_RISE], ctl[CTL_FALL]);
      wire        zEdge   = edgeHit(indexInput[i], zPrevReg[i], ctl[CTL_IDX_POL],
                                    !ctl[CTL_IDX_POL]);
      wire        zLevel  = indexInput[i] == ctl[CTL_IDX_POL];
      // levels equal on a B edge means A leads: count up
      wire        same    = phaseAInput[i] == phaseBInput[i];
      wire        extMode = (mode == MODE_UPDN) || (mode == MODE_X2) || (mode == MODE_X4);
      wire        zUse    = extMode && ctl[CTL_IDX_EN];
      wire        gateOk  = !(zUse && ctl[CTL_IDX_GATE]) || zLevel;   // RULE_07
      wire        clr     = zUse && !ctl[CTL_IDX_GATE] && zEdge;      // RULE_07
      wire        tick    = ctl[CTL_CLKSEL] ? tick4 : tick2;          // RULE_02
      wire        upRaw   = (mode == MODE_TIMER) ? tick :
                            (mode == MODE_UPDN)  ? aSel :                            // RULE_03
                            (mode == MODE_X2)    ? (bAny & same) :                   // RULE_05
                            (mode == MODE_X4)    ? ((bAny & same) | (aAny & !same)) : // RULE_06
                            1'b0;
      wire        dnRaw   = (mode == MODE_UPDN)  ? bSel :                            // RULE_04
                            (mode == MODE_X2)    ? (bAny & !same) :                  // RULE_05
                            (mode == MODE_X4)    ? ((bAny & !same) | (aAny & same)) : // RULE_06
                            1'b0;
      // opposite steps in one cycle cancel instead of picking a side
      wire        up      = active && gateOk && upRaw && !dnRaw;
      wire        dn      = active && gateOk && dnRaw && !upRaw;
      wire [15:0] maxV    = wide ? 16'hffff : 16'h00ff;
      wire [15:0] cur     = wide ? cntReg : {8'h00, cntReg[8*i +: 8]};
      wire [15:0] cmpV    = wide ? cmpReg : {8'h00, cmpReg[8*i +: 8]};
      wire [15:0] rldV    = wide ? rldReg : {8'h00, rldReg[8*i +: 8]};
      wire        ovf     = up && (cur == maxV);                      // RULE_12
      wire        unf     = dn && (cur == 16'h0000);                  // RULE_12
      wire [15:0] stepV   = ovf ? 16'h0000 : unf ? maxV :
                            up ? cur + 16'h0001 : dn ? cur - 16'h0001 : cur;
      wire        match   = (up || dn) && (stepV == cmpV) && !clr;    // RULE_11
      wire        dirChg  = (up && !upReg[i]) || (dn && upReg[i]);    // RULE_10

      assign laneNext[i] = clr ? 16'h0000 :
                           (match && act[1]) ? rldV : stepV;          // RULE_08
      assign laneSet[i]  = {dirChg, unf, ovf, match && act[0]};       // RULE_08
      assign laneStep[i] = up || dn;
      assign laneUp[i]   = up;                                        // RULE_09
   end

   // =====================================================================
   // register decode
   // unmapped indexes raise no strobe, so such writes are dropped
   wire wrCtrl0 = regWr && (regAddr == ADDR_CTRL0);
   wire wrCtrl1 = regWr && (regAddr == ADDR_CTRL1);
   wire wrStat0 = regWr && (regAddr == ADDR_STAT0);
   wire wrStat1 = regWr && (regAddr == ADDR_STAT1);
   wire wrCmp   = regWr && (regAddr == ADDR_CMP);
   wire wrRld   = regWr && (regAddr == ADDR_RLD);
   wire wrCount = regWr && (regAddr == ADDR_COUNT);
   wire wrCfg   = regWr && (regAddr == ADDR_CONFIG);

   // software count write beats any step in the same cycle
   wire [15:0] cntNext = wrCount ? regWrData :
                         wideReg ? laneNext[0] : {laneNext[1][7:0], laneNext[0][7:0]};

   // flags: write one to clear, a new event in the same cycle still sets
   wire [3:0] flag0Next = (flagReg[0] & ~({4{wrStat0}} & regWrData[3:0])) | laneSet[0];
   wire [3:0] flag1Next = (flagReg[1] & ~({4{wrStat1}} & regWrData[3:0])) | laneSet[1];
   wire [1:0] upNext    = (laneStep & laneUp) | (~laneStep & upReg);    // RULE_09

   // read mux; unmapped addresses read zero
   wire [15:0] rdMux =
      (regAddr == ADDR_CTRL0)  ? ctrlReg[0] :
      (regAddr == ADDR_CTRL1)  ? ctrlReg[1] :
      (regAddr == ADDR_STAT0)  ? {11'h000, upReg[0], flagReg[0]} :
      (regAddr == ADDR_STAT1)  ? {11'h000, upReg[1], flagReg[1]} :
      (regAddr == ADDR_CMP)    ? cmpReg :
      (regAddr == ADDR_RLD)    ? rldReg :
      (regAddr == ADDR_COUNT)  ? cntReg :
      (regAddr == ADDR_CONFIG) ? {15'h0000, wideReg} : 16'h0000;

   // =====================================================================
   // configuration registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrlReg[0] <= CTRL_RST;
         ctrlReg[1] <= CTRL_RST;
         cmpReg     <= WORD_RST;
         rldReg     <= WORD_RST;
         wideReg    <= 1'b0;
      end
      else
      begin
         if (wrCtrl0) ctrlReg[0] <= regWrData;
         if (wrCtrl1) ctrlReg[1] <= regWrData;
         if (wrCmp)   cmpReg     <= regWrData;
         if (wrRld)   rldReg     <= regWrData;
         if (wrCfg)   wideReg    <= regWrData[CFG_WIDE];   // RULE_01
      end
   end

   // counter, flags, pin history and prescaler
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cntReg     <= WORD_RST;
         flagReg[0] <= 4'h0;
         flagReg[1] <= 4'h0;
         upReg      <= 2'h0;
         prescReg   <= 2'h0;
         aPrevReg   <= 2'h0;
         bPrevReg   <= 2'h0;
         zPrevReg   <= 2'h0;
      end
      else
      begin
         cntReg     <= cntNext;
         flagReg[0] <= flag0Next;                          // RULE_11
         flagReg[1] <= flag1Next;                          // RULE_12
         upReg      <= upNext;
         prescReg   <= prescReg + 2'h1;
         aPrevReg   <= phaseAInput;
         bPrevReg   <= phaseBInput;
         zPrevReg   <= indexInput;
      end
   end

   // read data register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         regRdData <= 16'h0000;
      else if (regRd)
         regRdData <= rdMux;
   end

   // =====================================================================
   // interrupt requests: level, held while flag and enable are both set
   // a request drops in the cycle after software clears its flag
   for (genvar i = 0; i < 2; i++)
   begin : g_irq
      assign cmpIrq[i] = flagReg[i][ST_CMP] & ctrlReg[i][CTL_IE_CMP];          // RULE_11
      assign evtIrq[i] = ((flagReg[i][ST_OVF] | flagReg[i][ST_UNF])
                          & ctrlReg[i][CTL_IE_WRAP])                          // RULE_12
                       | (flagReg[i][ST_DIR] & ctrlReg[i][CTL_IE_DIR]);       // RULE_10
   end
endmodule

//--- verification/updown_counter_checker.sv
// Purpose: port checks for the up/down counter
// Assumes: bound to updown_counter; bench puts one idle cycle between write and read
// Notes:   count values themselves are judged by the bench
`timescale 1ns/100ps
module updown_counter_checker
   import updown_counter_pkg::*;
(
   input wire logic        clk,       // clock
   input wire logic        rst_n,     // reset, active low
   input wire logic [3:0]  regAddr,   // register index
   input wire logic [15:0] regWrData, // write data
   input wire logic        regWr,     // write strobe
   input wire logic        regRd,     // read strobe
   input wire logic [15:0] regRdData, // read data
   input wire logic [1:0]  cmpIrq,    // match requests
   input wire logic [1:0]  evtIrq     // event requests
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // =====
   // decode of control writes, shared by the mask checks
   wire ctl0Wr = regWr && (regAddr == ADDR_CTRL0);
   wire ctl1Wr = regWr && (regAddr == ADDR_CTRL1);
   // write, idle cycle, read of the same word
   sequence wrThenRd(a);
      regWr && regAddr == a ##2 regRd && regAddr == a;
   endsequence
   property readBack(a, mask);
      wrThenRd(a) |=> ((regRdData ^ $past(regWrData, 3)) & mask) == 16'h0000;
   endproperty
   chk_cmp_readback: assert property (readBack(ADDR_CMP, 16'hffff))
      else $error("compare value readback wrong");
   chk_rld_readback: assert property (readBack(ADDR_RLD, 16'hffff))
      else $error("reload value readback wrong");
   chk_ctrl_readback: assert property (readBack(ADDR_CTRL0, 16'h3fff))
      else $error("control readback wrong");
   chk_unmapped_zero: assert property (regRd && regAddr[3] |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   chk_rd_hold: assert property (!regRd |=> $stable(regRdData))
      else $error("read data moved without a read");
   chk_cmp_mask: assert property (ctl0Wr && !regWrData[CTL_IE_CMP] |=> !cmpIrq[0])
      else $error("match request not masked");
   chk_cmp_mask_hi: assert property (ctl1Wr && !regWrData[CTL_IE_CMP] |=> !cmpIrq[1])
      else $error("high channel match request not masked");
   chk_evt_mask: assert property (ctl0Wr && !regWrData[CTL_IE_WRAP] && !regWrData[CTL_IE_DIR]
      |=> !evtIrq[0])
      else $error("event request not masked");
   chk_reset_quiet: assert property ($rose(rst_n) |-> cmpIrq == 2'h0 && evtIrq == 2'h0)
      else $error("request active out of reset");
endmodule

//--- verification/quad_encoder_model.sv
// Purpose: encoder and pulse source on the counter pins
// Assumes: pins change just after a rising edge, at most once a cycle
// Notes:   pulse is only used while both phases are low
`timescale 1ns/100ps
module quad_encoder_model
(
   input  wire logic       clk,         // bench clock
   output logic      [1:0] phaseAInput, // phase A per channel
   output logic      [1:0] phaseBInput, // phase B per channel
   output logic      [1:0] indexInput   // index per channel
);
   int pos [2];
   // =====
   // shaft position 0..3 gives A,B = 00,10,11,01; forward must count up
   initial
   begin
      pos = '{0, 0};
      phaseAInput = 2'h0;
      phaseBInput = 2'h0;
      indexInput = 2'h0;
   end
   // one gray step a cycle; negative n turns backwards
   task automatic move(input int ch, input int n);
      repeat ((n < 0) ? -n : n)
      begin
         @(posedge clk);
         pos[ch] = (pos[ch] + ((n < 0) ? 3 : 1)) % 4;
         phaseAInput[ch] <= (pos[ch] == 1) || (pos[ch] == 2);
         phaseBInput[ch] <= pos[ch] >= 2;
      end
   endtask
   // rising then falling edge on one phase
   task automatic pulse(input int ch, input bit onB);
      repeat (2)
      begin
         @(posedge clk);
         if (onB)
            phaseBInput[ch] <= ~phaseBInput[ch];
         else
            phaseAInput[ch] <= ~phaseAInput[ch];
      end
   endtask
   task automatic setIdx(input int ch, input logic v);
      @(posedge clk);
      indexInput[ch] <= v;
   endtask
endmodule

//--- verification/quadrature_updown_counter_test.sv
// Purpose: self-checking bench for the up/down counter
// Assumes: 40 MHz clock, bus strobes one cycle each
// Notes:   seed 21; expectations come from the bench functions
`timescale 1ns/100ps
module quadrature_updown_counter_test
   import updown_counter_pkg::*;
;
   logic clk, rst_n, regWr, regRd;
   logic [3:0] regAddr;
   logic [15:0] regWrData, regRdData, q, d;
   logic [1:0] phaseAInput, phaseBInput, indexInput, cmpIrq, evtIrq;
   logic [2:0] md;
   int errCount = 0;
   int samplesChecked = 0;
   int n;
   updown_counter uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .phaseAInput(phaseAInput),
      .phaseBInput(phaseBInput), .indexInput(indexInput), .cmpIrq(cmpIrq), .evtIrq(evtIrq));
   quad_encoder_model enc (.clk(clk), .phaseAInput(phaseAInput), .phaseBInput(phaseBInput),
      .indexInput(indexInput));
   // =====
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // data sampled mid-cycle so the capture edge has settled
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      q = regRdData;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         errCount++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [15:0] exp, input string what);
      rd(a);
      chk(what, q, exp);
   endtask
   // x4 counts every gray step, x2 only phase B edges
   function automatic logic [15:0] qExp(input logic [2:0] m, input int s);
      return (m == MODE_X4) ? 16'(s) : 16'(s / 2);
   endfunction
   task automatic results;
      $display("checks %0d errors %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, over forty times the expected run length
   initial
   begin
      repeat (20000) @(posedge clk);
      errCount++;
      results();
   end
   initial
   begin
      rst_n = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWrData = 16'h0000;
      void'($urandom(21));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 16; a++)
         rdChk(4'(a), 16'h0000, "reset");
      wr(4'h9, 16'($urandom));
      rdChk(4'h9, 16'h0000, "unmapped");
      repeat (4)
      begin
         d = 16'($urandom);
         wr(ADDR_CMP, d);
         rdChk(ADDR_CMP, d, "cmp");
         wr(ADDR_RLD, ~d);
         rdChk(ADDR_RLD, ~d, "rld");
         wr(ADDR_CTRL0, d & 16'h3fff);
         rdChk(ADDR_CTRL0, d & 16'h3fff, "ctrl");
      end
      // timer in 16-bit mode: 40 enabled cycles, wraps only at clock/2
      wr(ADDR_CONFIG, 16'h0001);
      for (int s = 0; s < 2; s++)
      begin
         wr(ADDR_CTRL0, 16'h1000);
         wr(ADDR_STAT0, 16'h001f);
         wr(ADDR_COUNT, 16'hfff0);
         wr(ADDR_CTRL0, 16'(MODE_TIMER) | 16'(s) << CTL_CLKSEL | 16'h1000);
         repeat (38) @(posedge clk);
         wr(ADDR_CTRL0, 16'h1000);
         rdChk(ADDR_COUNT, 16'hfff0 + 16'(40 >> (s + 1)), "timer");
         chk("wrapIrq", 16'(evtIrq[0]), 16'(s == 0));
      end
      // quadrature forward, then back through zero
      for (int m = 0; m < 2; m++)
      begin
         md = m ? MODE_X4 : MODE_X2;
         wr(ADDR_CTRL0, 16'(md));
         wr(ADDR_COUNT, 16'h0000);
         wr(ADDR_STAT0, 16'h001f);
         enc.move(0, 12);
         rdChk(ADDR_COUNT, qExp(md, 12), "fwd");
         rd(ADDR_STAT0);
         chk("upFlag", q & 16'h0016, 16'h0010);
         enc.move(0, -16);
         rdChk(ADDR_COUNT, qExp(md, -4), "rev");
         rd(ADDR_STAT0);
         chk("unfDir", q & 16'h001e, 16'h000c);
      end
      // 8-bit mode, high channel: rise, fall and both edges
      wr(ADDR_CONFIG, 16'h0000);
      for (int e = 1; e < 4; e++)
      begin
         wr(ADDR_COUNT, 16'h0000);
         wr(ADDR_CTRL1, 16'(MODE_UPDN) | 16'(e) << CTL_RISE);
         n = $urandom_range(3, 6);
         repeat (n) enc.pulse(1, 0);
         enc.pulse(1, 1);
         rdChk(ADDR_COUNT, 16'((n - 1) * $countones(e)) << 8, "updown");
      end
      wr(ADDR_COUNT, 16'h0000);
      wr(ADDR_CTRL1, 16'h01d2);
      enc.pulse(1, 0);
      enc.setIdx(1, 1'b1);
      enc.pulse(1, 0);
      rdChk(ADDR_COUNT, 16'h0100, "gate");
      wr(ADDR_CTRL1, 16'h0152);
      enc.setIdx(1, 1'b0);
      enc.pulse(1, 0);
      enc.setIdx(1, 1'b1);
      rdChk(ADDR_COUNT, 16'h0000, "clear");
      // high channel steps down from zero: wraps to its own 8-bit maximum
      wr(ADDR_STAT1, 16'h001f);
      wr(ADDR_CTRL1, 16'h1012);
      enc.pulse(1, 1);
      rdChk(ADDR_COUNT, 16'hff00, "wrap8");
      chk("wrapIrqHi", 16'(evtIrq[1]), 16'h0001);
      wr(ADDR_CTRL1, 16'h0000);
      // every compare action on the low channel
      for (int act = 0; act < 4; act++)
      begin
         wr(ADDR_CTRL0, 16'(MODE_UPDN) | 16'h0810 | 16'(act) << CTL_ACT_LSB);
         wr(ADDR_STAT0, 16'h001f);
         wr(ADDR_CMP, 16'h0003);
         wr(ADDR_RLD, 16'h0040);
         wr(ADDR_COUNT, 16'h0000);
         repeat (3) enc.pulse(0, 0);
         @(negedge clk);
         chk("cmpIrq", 16'(cmpIrq[0]), 16'(act[0]));
         rdChk(ADDR_COUNT, act[1] ? 16'h0040 : 16'h0003, "reload");
      end
      // up step keeps direction, down step raises the direction request
      wr(ADDR_CTRL0, 16'h2012);
      wr(ADDR_STAT0, 16'h001f);
      enc.pulse(0, 0);
      @(negedge clk);
      chk("dirIrq", 16'(evtIrq[0]), 16'h0000);
      enc.pulse(0, 1);
      @(negedge clk);
      chk("dirIrq", 16'(evtIrq[0]), 16'h0001);
      results();
   end
endmodule
bind updown_counter updown_counter_checker checker_i (.clk(clk), .rst_n(rst_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .cmpIrq(cmpIrq), .evtIrq(evtIrq));
